// ---- dv/char_display_setup_and_ram_access_bench.sv ----
// Self-checking bench for the display instruction decoder.
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h want %h", $time, a, e); end end
module char_display_setup_and_ram_access_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import char_disp_pkg::*;
    logic mclk, resetn, dir, shen, rs, rw, en, hoe, oe;
    logic bw, lc, fs, busy, gsel, spulse, sleft;
    logic [7:0] hdata, dout, dline, q;
    logic [6:0] ac;
    int fails = 0, n_checks = 0, n_shift = 0;
    // Released host lines show the inverse of their last value.
    assign dline = oe ? dout : (hoe ? hdata : ~hdata);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Counts display shifts so writes and reads can be told apart.
    always @(posedge mclk) if (spulse) n_shift++;
    char_host_model host (.mclk(mclk), .rdata(dline), .rs(rs), .rw(rw),
        .en(en), .hdata(hdata), .hoe(hoe));
    char_disp_core #(.EXEC_LEN(40)) DUT (.mclk(mclk), .resetn(resetn),
        .register_select_line(rs), .read_write_select(rw),
        .enable_strobe(en), .data_line_in(dline), .data_line_out(dout),
        .data_line_oe(oe), .address_step_direction(dir),
        .display_shift_enable(shen), .bus_width_flag(bw),
        .line_count_flag(lc), .font_select_flag(fs), .busy_indicator(busy),
        .addr_counter(ac), .glyph_selected(gsel),
        .display_shift_pulse(spulse), .display_shift_left(sleft));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // Polls the status byte until busy clears, with a bounded count.
    task automatic idle();
        logic [7:0] s;
        for (int i = 0; i < 50; i++) begin
            host.acc(1'b0, 1'b1, 8'h00, s);
            if (s[7] === 1'b0) return;
        end
        fails++;
        give_verdict();
    endtask : idle
    task automatic wr(input logic r, input logic [7:0] d);
        idle();
        host.acc(r, 1'b0, d, q);
        // The byte is taken on the host's last edge; let that edge settle.
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] e);
        idle();
        host.acc(1'b1, 1'b1, 8'h00, q);
        `CHK(q, e)
    endtask : rd
    task automatic ac_is(input logic [6:0] e);
        idle();
        `CHK(ac, e)
    endtask : ac_is
    initial begin
        resetn = 1'b0;
        dir = 1'b1;
        shen = 1'b1;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        `CHK({bw, lc, fs, busy, ac}, {4'h8, 7'h00})
        wr(1'b0, 8'h3C);
        host.acc(1'b0, 1'b1, 8'h00, q);
        `CHK(q, 8'h80)
        host.acc(1'b0, 1'b0, 8'h85, q);
        ac_is(7'h00);
        `CHK({bw, lc, fs}, 3'h7)
        $display("test config done");
        wr(1'b0, 8'hA7);
        `CHK(gsel, 1'b0)
        wr(1'b1, 8'hA1);
        ac_is(7'h40);
        `CHK(n_shift, 1)
        `CHK(sleft, 1'b1)
        wr(1'b1, 8'hB2);
        ac_is(7'h41);
        wr(1'b0, 8'hA7);
        rd(8'hA1);
        ac_is(7'h40);
        rd(8'hB2);
        `CHK(n_shift, 2)
        shen <= 1'b0;
        dir <= 1'b0;
        wr(1'b0, 8'hC0);
        rd(8'hB2);
        ac_is(7'h27);
        wr(1'b0, 8'h14);
        ac_is(7'h40);
        rd(8'hB2);
        dir <= 1'b1;
        wr(1'b0, 8'hA7);
        wr(1'b1, 8'hC3);
        rd(8'hA1);
        $display("test display done");
        wr(1'b0, 8'h7F);
        `CHK({gsel, ac}, 8'hBF)
        wr(1'b1, 8'h1F);
        ac_is(7'h00);
        wr(1'b0, 8'h7F);
        rd(8'h1F);
        wr(1'b0, 8'h30);
        `CHK(lc, 1'b0)
        `CHK(fs, 1'b0)
        wr(1'b0, 8'hCF);
        wr(1'b1, 8'h55);
        ac_is(7'h00);
        $display("test glyph done");
        wr(1'b0, 8'h20);
        host.nib = 1'b1;
        `CHK(bw, 1'b0)
        wr(1'b0, 8'h85);
        ac_is(7'h05);
        host.acc(1'b0, 1'b1, 8'h00, q);
        `CHK(q, 8'h05)
        wr(1'b0, 8'h30);
        host.nib = 1'b0;
        `CHK(bw, 1'b1)
        $display("test nibble done");
        give_verdict();
    end
endmodule : char_display_setup_and_ram_access_bench

// ---- dv/char_host_model.sv ----
// Host processor model that drives the display pins strobe by strobe.
module char_host_model (
    input wire logic mclk, // System clock.
    input wire logic [7:0] rdata, // Level seen on the data lines.
    output logic rs, // Register select.
    output logic rw, // High for reads.
    output logic en, // Transfer strobe.
    output logic [7:0] hdata, // Byte driven by the host.
    output logic hoe // High while the host drives the lines.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic nib = 1'b0; // Set by the bench while nibble mode is on.
    initial begin
        {rs, rw, en, hoe} = 4'h0;
        hdata = 8'h00;
    end
    // One strobe; setup and hold are five clocks and the strobe six, because the device
    // needs several clocks to agree on each pin.
    task automatic put(input logic r, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge mclk);
        rs <= r;
        rw <= w;
        hdata <= d;
        hoe <= ~w;
        repeat (5) @(posedge mclk);
        en <= 1'b1;
        repeat (6) @(posedge mclk);
        q = rdata; // Read data is taken at the edge that drops the strobe.
        en <= 1'b0;
        repeat (5) @(posedge mclk);
        hoe <= 1'b0;
    endtask : put
    // Whole byte; in nibble mode the upper half travels first.
    task automatic acc(input logic r, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        logic [7:0] hi;
        logic [7:0] lo;
        if (nib) begin
            put(r, w, {d[7:4], 4'h0}, hi);
            put(r, w, {d[3:0], 4'h0}, lo);
            q = {hi[7:4], lo[7:4]};
        end else begin
            put(r, w, d, q);
        end
    endtask : acc
endmodule : char_host_model

// ---- pkg/char_disp_pkg.sv ----
// Shared constants and types for the character display instruction decoder.
package char_disp_pkg;

    // Clock period and the execution time of one instruction.
    localparam int CLK_PERIOD_NS = 100;
    localparam int EXEC_TIME_NS = 38000;
    // Longest time, so the count rounds down to whole cycles.
    localparam int EXEC_CYCLES = EXEC_TIME_NS / CLK_PERIOD_NS;

    // Synchroniser layout: strobe, select lines, then the data lines.
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int SYNC_PINS = DATA_W + 3;
    localparam int PIN_EN = DATA_W + 2;
    localparam int PIN_RS = DATA_W + 1;
    localparam int PIN_RW = DATA_W;

    // Address widths and memory depths.
    localparam int ADDR_W = 7;
    localparam int GLYPH_AW = 6;
    localparam int GLYPH_DEPTH = 64;
    localparam int DISP_DEPTH = 128;

    // Instruction field positions and patterns.
    localparam int TOP_BIT = 7;
    localparam int GLYPH_BIT = 6;
    localparam int FUNC_HI = 7;
    localparam int FUNC_LO = 5;
    localparam logic [2:0] FUNC_PAT = 3'h1;
    localparam logic [3:0] CURSOR_PAT = 4'h1;
    localparam int DL_BIT = 4;
    localparam int N_BIT = 3;
    localparam int F_BIT = 2;
    localparam int SC_BIT = 3;
    localparam int RL_BIT = 2;

    // Display address map.
    localparam logic [6:0] ADDR_ZERO = 7'h00;
    localparam logic [6:0] ONE_LINE_END = 7'h4F;
    localparam logic [6:0] LINE1_END = 7'h27;
    localparam logic [6:0] LINE2_START = 7'h40;
    localparam logic [6:0] LINE2_END = 7'h67;

    // Reset values of the configuration flags and of the data path.
    localparam logic RST_BUS_WIDTH = 1'b1;
    localparam logic RST_LINES = 1'b0;
    localparam logic RST_FONT = 1'b0;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Execution sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_STEP = 2'b10
    } exec_state_t;

endpackage : char_disp_pkg

// ---- src/char_disp_core.sv ----
// Instruction decoder, address counter and RAM access for a char display.

// Summary of operation
// - Decode 001 pattern as configuration instruction.
// - Width flag picks eight lines or nibbles.
// - Line flag picks one or two lines.
// - Font flag picks five by seven/ten.
// - Pattern 01 loads glyph address, selects glyph.
// - Top bit loads display address, selects display.
// - One line spans 00 to 4F.
// - Two lines: 00-27 and 40-67.
// - Status read returns busy and address.
// - Busy ignores new instructions until clear.
// - One address counter serves both RAMs.
// - Data write stores byte in selected RAM.
// - Write steps address, may shift display.
// - Data read returns byte from selected RAM.
// - First read without address load invalid.
// - Cursor move primes display read path.
// - Read steps address, never shifts display.
// - Read right after write returns stale data.
// - Data access steps address after busy clears; cursor move steps it at once.
// - Direction input chooses increment or decrement.
// - Instructions finish within execution time.
module char_disp_core
    import char_disp_pkg::*;
#(
    parameter int EXEC_LEN = EXEC_CYCLES // Busy cycles per instruction.
) (
    input wire logic mclk, // System clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic register_select_line, // Pin: 0 command, 1 data.
    input wire logic read_write_select, // Pin: 1 reads from device.
    input wire logic enable_strobe, // Pin: transfer strobe.
    input wire logic [DATA_W-1:0] data_line_in, // Pins: data lines in.
    output logic [DATA_W-1:0] data_line_out, // Pins: data lines out.
    output logic data_line_oe, // High while device drives lines.
    input wire logic address_step_direction, // 1 steps up, 0 down.
    input wire logic display_shift_enable, // Shift display on write.
    output logic bus_width_flag, // 1 eight lines, 0 nibbles.
    output logic line_count_flag, // 1 two lines, 0 one line.
    output logic font_select_flag, // 1 tall font, 0 short font.
    output logic busy_indicator, // High while executing.
    output logic [ADDR_W-1:0] addr_counter, // Shared address counter.
    output logic glyph_selected, // 1 glyph RAM, 0 display RAM.
    output logic display_shift_pulse, // One cycle per display shift.
    output logic display_shift_left // Direction of that shift.
);

    localparam int CNT_W = $clog2(EXEC_LEN + 1);

    // Synchroniser stages and the agreed pin values.
    logic [SYNC_PINS-1:0] pin_vec; // Raw pins gathered.
    logic [SYNC_PINS-1:0] s1_ff; // First stage, read only by s2.
    logic [SYNC_PINS-1:0] s2_ff; // Second stage.
    logic [SYNC_PINS-1:0] s3_ff; // Third stage.
    logic [SYNC_PINS-1:0] stab_ff; // Value once stages agree.

    // Transfer tracking.
    logic en_prev_ff; // Strobe one cycle ago.
    logic nib_ff; // Upper nibble already taken.
    logic [NIB_W-1:0] hi_nib_ff; // Stored upper nibble.
    logic en_st, rs_st, rw_st, en_fall, en_rise;
    logic [DATA_W-1:0] data_st; // Agreed data lines.
    logic [DATA_W-1:0] xfer_byte; // Completed byte.
    logic xfer_done, status_rd, take, cmd_take, wr_take, rd_take;
    logic dec_disp, dec_glyph, dec_func, dec_cursor;

    // Execution state.
    exec_state_t state_ff; // Sequencer state.
    logic [CNT_W-1:0] cnt_ff; // Cycles spent busy.
    logic busy_ff; // Busy indicator register.
    logic step_rd_ff; // Step pending after a read.
    logic step_wr_ff; // Step pending after a write.

    // Address counter, configuration and read path.
    logic [ADDR_W-1:0] addr_counter_ff; // Shared address counter.
    logic glyph_sel_ff; // Target RAM of data accesses.
    logic bus_width_ff, line_count_ff, font_ff; // Configuration.
    logic prime_ff; // Reload read latch next edge.
    logic [DATA_W-1:0] read_latch_ff; // Byte handed to data reads.
    logic [DATA_W-1:0] rd_byte; // RAM byte at the counter.
    logic shift_pulse_ff, shift_left_ff;
    logic [DATA_W-1:0] data_out_ff;
    logic data_oe_ff;

    // Character memories.
    logic [DATA_W-1:0] glyph_mem [GLYPH_DEPTH]; // Glyph patterns.
    logic [DATA_W-1:0] disp_mem [DISP_DEPTH]; // Character codes.

    // Next address after one step, honouring the line map of each mode.
    function automatic logic [ADDR_W-1:0] step_addr(
        input logic [ADDR_W-1:0] a,
        input logic up,
        input logic glyph,
        input logic two
    );
        logic [GLYPH_AW-1:0] g;
        logic [ADDR_W-1:0] r;
        g = up ? a[GLYPH_AW-1:0] + 1'b1 : a[GLYPH_AW-1:0] - 1'b1;
        if (glyph) begin
            r = {1'b0, g};
        end else if (up) begin
            if (two && a == LINE1_END) begin
                r = LINE2_START;
            end else if (two && a == LINE2_END) begin
                r = ADDR_ZERO;
            end else if (!two && a == ONE_LINE_END) begin
                r = ADDR_ZERO;
            end else begin
                r = a + 1'b1;
            end
        end else begin
            if (two && a == LINE2_START) begin
                r = LINE1_END;
            end else if (two && a == ADDR_ZERO) begin
                r = LINE2_END;
            end else if (!two && a == ADDR_ZERO) begin
                r = ONE_LINE_END;
            end else begin
                r = a - 1'b1;
            end
        end
        return r;
    endfunction : step_addr

    // All pins come from the host's domain and pass three stages.
    assign pin_vec = {enable_strobe, register_select_line,
                      read_write_select, data_line_in};

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= pin_vec;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A pin change counts only once the second and third stages agree.
    for (genvar i = 0; i < SYNC_PINS; i++) begin : g_agree
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                stab_ff[i] <= 1'b0;
            end else if (s2_ff[i] == s3_ff[i]) begin
                stab_ff[i] <= s3_ff[i];
            end
        end
    end

    assign en_st = stab_ff[PIN_EN];
    assign rs_st = stab_ff[PIN_RS];
    assign rw_st = stab_ff[PIN_RW];
    assign data_st = stab_ff[DATA_W-1:0];
    assign en_fall = en_prev_ff & ~en_st;
    assign en_rise = ~en_prev_ff & en_st;

    // In nibble mode a byte completes on the second falling strobe.
    assign xfer_done = en_fall & (bus_width_ff | nib_ff);
    assign xfer_byte = bus_width_ff ? data_st
                     : {hi_nib_ff, data_st[DATA_W-1 -: NIB_W]};
    assign status_rd = ~rs_st & rw_st;

    // Anything but a status read is dropped unless the sequencer is idle.
    assign take = xfer_done & ~status_rd & (state_ff == ST_IDLE);
    assign cmd_take = take & ~rs_st & ~rw_st;
    assign wr_take = take & rs_st & ~rw_st;
    assign rd_take = take & rs_st & rw_st;

    // Instruction decode, in priority order of the top bits.
    assign dec_disp = xfer_byte[TOP_BIT];
    assign dec_glyph = ~xfer_byte[TOP_BIT] & xfer_byte[GLYPH_BIT];
    assign dec_func = xfer_byte[FUNC_HI:FUNC_LO] == FUNC_PAT;
    assign dec_cursor = (xfer_byte[DATA_W-1 -: NIB_W] == CURSOR_PAT)
                      & ~xfer_byte[SC_BIT];

    // Byte reads come from the counter's RAM, picked by the last load.
    assign rd_byte = glyph_sel_ff ? glyph_mem[addr_counter_ff[GLYPH_AW-1:0]]
                   : disp_mem[addr_counter_ff];

    // Strobe edge history and nibble pairing.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            en_prev_ff <= 1'b0;
            nib_ff <= 1'b0;
            hi_nib_ff <= NIB_ZERO;
        end else begin
            en_prev_ff <= en_st;
            if (bus_width_ff) begin
                nib_ff <= 1'b0; // Full width never pairs nibbles.
            end else if (en_fall) begin
                // Upper half first; the pair counts even while busy.
                nib_ff <= ~nib_ff;
                if (!nib_ff) begin
                    hi_nib_ff <= data_st[DATA_W-1 -: NIB_W];
                end
            end
        end
    end

    // Execution sequencer: busy for a fixed time, then any pending step.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            step_rd_ff <= 1'b0;
            step_wr_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (take) begin
                        state_ff <= ST_BUSY;
                        cnt_ff <= '0;
                        busy_ff <= 1'b1;
                        step_rd_ff <= rd_take;
                        step_wr_ff <= wr_take;
                    end
                end
                ST_BUSY: begin
                    // A fixed length keeps every instruction in budget.
                    if (cnt_ff == CNT_W'(EXEC_LEN - 1)) begin
                        busy_ff <= 1'b0;
                        if (step_rd_ff || step_wr_ff) begin
                            state_ff <= ST_STEP;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                ST_STEP: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                    busy_ff <= 1'b0;
                end
            endcase
        end
    end

    // Address counter, target RAM and configuration flags.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            addr_counter_ff <= ADDR_ZERO;
            glyph_sel_ff <= 1'b0;
            bus_width_ff <= RST_BUS_WIDTH;
            line_count_ff <= RST_LINES;
            font_ff <= RST_FONT;
            prime_ff <= 1'b0;
        end else begin
            prime_ff <= 1'b0;
            if (cmd_take) begin
                if (dec_disp) begin
                    addr_counter_ff <= xfer_byte[ADDR_W-1:0];
                    glyph_sel_ff <= 1'b0;
                    prime_ff <= 1'b1;
                end else if (dec_glyph) begin
                    addr_counter_ff <= {1'b0,
                        xfer_byte[GLYPH_AW-1:0]};
                    glyph_sel_ff <= 1'b1;
                    prime_ff <= 1'b1;
                end else if (dec_func) begin
                    bus_width_ff <= xfer_byte[DL_BIT];
                    line_count_ff <= xfer_byte[N_BIT];
                    font_ff <= xfer_byte[F_BIT];
                end else if (dec_cursor) begin
                    // Moving the cursor steps the counter and primes reads like a load.
                    addr_counter_ff <= step_addr(addr_counter_ff,
                        xfer_byte[RL_BIT], 1'b0, line_count_ff);
                    glyph_sel_ff <= 1'b0;
                    prime_ff <= 1'b1;
                end
            end else if (state_ff == ST_STEP) begin
                // The step waits until busy has already dropped.
                addr_counter_ff <= step_addr(addr_counter_ff,
                    address_step_direction, glyph_sel_ff,
                    line_count_ff);
                // Only a read refetches; a write leaves the latch stale.
                prime_ff <= step_rd_ff;
            end
        end
    end

    // Memory writes: no reset, the contents are undefined at power up.
    always_ff @(posedge mclk) begin
        if (wr_take) begin
            if (glyph_sel_ff) begin
                glyph_mem[addr_counter_ff[GLYPH_AW-1:0]]
                    <= xfer_byte;
            end else begin
                disp_mem[addr_counter_ff] <= xfer_byte;
            end
        end
    end

    // Read latch: a read returns what was fetched earlier, not live RAM.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            read_latch_ff <= BYTE_ZERO;
        end else if (prime_ff) begin
            read_latch_ff <= rd_byte;
        end
    end

    // Display shift request, only for display writes with shift enabled.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            shift_pulse_ff <= 1'b0;
            shift_left_ff <= 1'b0;
        end else begin
            shift_pulse_ff <= (state_ff == ST_STEP) & step_wr_ff
                            & ~glyph_sel_ff & display_shift_enable;
            if ((state_ff == ST_STEP) && step_wr_ff) begin
                shift_left_ff <= address_step_direction;
            end
        end
    end

    // Read data drive; the byte or nibble is chosen at the strobe rise.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            data_out_ff <= BYTE_ZERO;
            data_oe_ff <= 1'b0;
        end else begin
            data_oe_ff <= en_st & rw_st;
            if (en_rise && rw_st) begin
                if (bus_width_ff) begin
                    data_out_ff <= rs_st ? read_latch_ff
                        : {busy_ff, addr_counter_ff};
                end else if (!nib_ff) begin
                    data_out_ff <= rs_st
                        ? {read_latch_ff[DATA_W-1 -: NIB_W], NIB_ZERO}
                        : {busy_ff, addr_counter_ff[ADDR_W-1 -: 3],
                           NIB_ZERO};
                end else begin
                    data_out_ff <= rs_st
                        ? {read_latch_ff[NIB_W-1:0], NIB_ZERO}
                        : {addr_counter_ff[NIB_W-1:0], NIB_ZERO};
                end
            end
        end
    end

    // Outputs come straight from registers.
    assign data_line_out = data_out_ff;
    assign data_line_oe = data_oe_ff;
    assign bus_width_flag = bus_width_ff;
    assign line_count_flag = line_count_ff;
    assign font_select_flag = font_ff;
    assign busy_indicator = busy_ff;
    assign addr_counter = addr_counter_ff;
    assign glyph_selected = glyph_sel_ff;
    assign display_shift_pulse = shift_pulse_ff;
    assign display_shift_left = shift_left_ff;

    // Length of the current busy period, kept for the timing check only.
    // A counter keeps the check cheap however long the busy time is.
    logic [CNT_W-1:0] busy_len_ff; // Cycles busy has stood so far.

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            busy_len_ff <= '0;
        end else if (busy_ff) begin
            busy_len_ff <= busy_len_ff + 1'b1;
        end else begin
            busy_len_ff <= '0;
        end
    end

    // Checks on the sequencer, decoder and address map.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_func_set;
        logic [DATA_W-1:0] v;
        (cmd_take && dec_func && !dec_glyph && !dec_disp, v = xfer_byte)
        |=> bus_width_ff == v[DL_BIT] && line_count_ff == v[N_BIT]
            && font_ff == v[F_BIT];
    endproperty
    a_func_set_flags: assert property (p_func_set)
        else $error("configuration flags not loaded");

    property p_glyph_load;
        logic [DATA_W-1:0] v;
        (cmd_take && dec_glyph, v = xfer_byte)
        |=> glyph_sel_ff && addr_counter_ff == {1'b0, v[GLYPH_AW-1:0]};
    endproperty
    a_glyph_addr_load: assert property (p_glyph_load)
        else $error("glyph address load wrong");

    property p_disp_load;
        logic [DATA_W-1:0] v;
        (cmd_take && dec_disp, v = xfer_byte)
        |=> !glyph_sel_ff && addr_counter_ff == v[ADDR_W-1:0];
    endproperty
    a_disp_addr_load: assert property (p_disp_load)
        else $error("display address load wrong");

    a_busy_length: assert property ($fell(busy_ff) |->
        busy_len_ff == CNT_W'(EXEC_LEN) && EXEC_LEN <= EXEC_CYCLES)
        else $error("busy time differs from execution time");

    a_busy_blocks_cmd: assert property (
        busy_ff && cnt_ff != CNT_W'(EXEC_LEN - 1) && xfer_done && !status_rd
        |=> $stable(addr_counter_ff) && $stable(bus_width_ff) && busy_ff)
        else $error("instruction taken while busy");

    a_ac_waits_busy: assert property (
        $past(busy_ff) && busy_ff |-> $stable(addr_counter_ff))
        else $error("address changed while busy");

    a_one_line_wrap: assert property (
        state_ff == ST_STEP && !glyph_sel_ff && !line_count_ff
        && address_step_direction && addr_counter_ff == ONE_LINE_END
        |=> addr_counter_ff == ADDR_ZERO)
        else $error("one line map does not wrap");

    a_two_line_gap: assert property (
        state_ff == ST_STEP && !glyph_sel_ff && line_count_ff
        && address_step_direction && addr_counter_ff == LINE1_END
        |=> addr_counter_ff == LINE2_START)
        else $error("two line map does not skip gap");

    a_status_read: assert property (
        en_rise && rw_st && !rs_st && bus_width_ff
        |=> data_out_ff == {$past(busy_ff), $past(addr_counter_ff)})
        else $error("status read data wrong");

    a_write_no_fetch: assert property (
        state_ff == ST_STEP && step_wr_ff |=> ##1 $stable(read_latch_ff))
        else $error("read latch refreshed after write");

    a_no_read_shift: assert property (
        shift_pulse_ff |-> $past(step_wr_ff) && !$past(glyph_sel_ff))
        else $error("display shifted on read or glyph access");

    c_nibble_write: cover property (wr_take && !bus_width_ff);
    c_data_read: cover property (rd_take ##[1:400] prime_ff);
    c_shift: cover property (shift_pulse_ff);
    c_cursor: cover property (cmd_take && dec_cursor);

endmodule : char_disp_core
